// ### design/cbac_top.sv
`timescale 1ns/100ps

module cbac_top #(
  parameter int NVM_BLOCKS = 32,
  parameter int LIST_MAX   = 15,
  parameter int BLK_BYTES  = 16
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     acc_valid,
  output cbac_pkg::cbac_acc_s      acc,
  output logic      [7:0]          acc_bytes
);

  // ********************************************
  // bus slave
  // ********************************************
  logic        resp_q;
  logic [31:0] rdata_q;
  wire         req     = avs_read | avs_write;
  wire         full_be = (avs_byteenable == 4'hf);
  wire         wr_fire = avs_write & resp_q & full_be;
  wire  [7:0]  addr    = {avs_address[7:2], 2'b00};

  // one wait state: answer at the second edge
  assign avs_waitrequest = req & ~resp_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      resp_q <= 1'b0;
    else
      resp_q <= req & ~resp_q;
  end

  wire sel_cmd  = wr_fire & (addr == cbac_pkg::REG_CMD);
  wire sel_svc  = wr_fire & (addr == cbac_pkg::REG_SVC);
  wire sel_blk  = wr_fire & (addr == cbac_pkg::REG_BLK);
  wire sel_ctrl = wr_fire & (addr == cbac_pkg::REG_CTRL);
  wire sel_rtd  = wr_fire & (addr == cbac_pkg::REG_RTD);
  wire sel_rom  = wr_fire & (addr == cbac_pkg::REG_ROM);
  wire sel_enc  = wr_fire & (addr == cbac_pkg::REG_ENC);

  // ********************************************
  // settings
  // ********************************************
  logic [7:0]  rtd_rd_q;
  logic [7:0]  rtd_wr_q;
  logic [31:0] rom_mask_q;
  logic [31:0] enc_mask_q;
  logic        unmnt_q;
  logic        unmnt_alt_q;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rtd_rd_q    <= cbac_pkg::RTD_RD_RST;
      rtd_wr_q    <= cbac_pkg::RTD_WR_RST;
      rom_mask_q  <= cbac_pkg::MASK_RST;
      enc_mask_q  <= cbac_pkg::MASK_RST;
      unmnt_q     <= 1'b0;
      unmnt_alt_q <= 1'b0;
    end
    else
    begin
      if (sel_rtd)
      begin
        rtd_rd_q <= avs_writedata[7:0];
        rtd_wr_q <= avs_writedata[15:8];
      end
      if (sel_rom)
        rom_mask_q <= avs_writedata;
      if (sel_enc)
        enc_mask_q <= avs_writedata;
      if (sel_ctrl)
      begin
        unmnt_q     <= avs_writedata[cbac_pkg::CTRL_UNMNT_BIT];
        unmnt_alt_q <= avs_writedata[cbac_pkg::CTRL_ALT_BIT];
      end
    end
  end

  // ********************************************
  // command header
  // ********************************************
  logic [7:0] cmd_q;
  logic [7:0] svc_k_q;
  logic [7:0] blk_m_q;
  logic [7:0] slot_req_q;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cmd_q      <= 8'h00;
      svc_k_q    <= 8'h00;
      blk_m_q    <= 8'h00;
      slot_req_q <= 8'h00;
    end
    else if (sel_cmd)
    begin
      cmd_q      <= avs_writedata[7:0];
      svc_k_q    <= avs_writedata[15:8];
      blk_m_q    <= avs_writedata[23:16];
      slot_req_q <= avs_writedata[31:24];
    end
  end

  wire is_rd = (cmd_q == cbac_pkg::CMD_READ);
  wire is_wr = (cmd_q == cbac_pkg::CMD_WRITE);

  // ********************************************
  // service list
  // ********************************************
  cbac_pkg::cbac_state_e state_q;
  logic [4:0]  svc_n_q;
  logic [15:0] svc_first_q;
  logic        svc_diff_q;
  wire         collect  = (state_q == cbac_pkg::ST_COLLECT);
  wire         svc_take = sel_svc & collect & (svc_n_q < 5'(LIST_MAX));
  wire         svc_ne   = (svc_n_q != 5'h00) & (avs_writedata[15:0] != svc_first_q);

  always_ff @(posedge clk)
  begin
    if (!nrst || sel_cmd)
    begin
      svc_n_q     <= 5'h00;
      svc_first_q <= 16'h0000;
      svc_diff_q  <= 1'b0;
    end
    else if (svc_take)
    begin
      svc_n_q <= svc_n_q + 5'h01;
      if (svc_n_q == 5'h00)
        svc_first_q <= avs_writedata[15:0];
      svc_diff_q <= svc_diff_q | svc_ne;
    end
  end

  // ********************************************
  // block list intake
  // ********************************************
  cbac_pkg::cbac_elem_s elem;
  logic [4:0]  blk_n_q;
  logic [7:0]  blk_num_q [LIST_MAX];
  logic [2:0]  mode_q;
  logic [7:0]  prev_q;
  logic        err_am_q;
  logic        err_mode_q;
  logic        err_ord_q;
  logic        err_rng_q;
  logic        err_area_q;

  assign elem = cbac_pkg::cbac_elem_s'(avs_writedata[24:0]);

  localparam logic [7:0] NVM_LIM = 8'(NVM_BLOCKS);

  wire       blk_take  = sel_blk & collect & (blk_n_q < 5'(LIST_MAX));
  wire       first     = (blk_n_q == 5'h00);
  // two-byte element is always plaintext
  wire [2:0] el_mode   = elem.three ? elem.d2[2:0] : cbac_pkg::MODE_PLAIN;
  wire       el_known  = (el_mode == cbac_pkg::MODE_PLAIN) | (el_mode == cbac_pkg::MODE_PRIV)
                       | (el_mode == cbac_pkg::MODE_FAM);
  wire       el_hi_bad = elem.three & (elem.d2[7:3] != 5'h00);
  wire       el_am_bad = (elem.d0[6:4] != 3'h0);
  wire       el_differ = ~first & (el_mode != mode_q);
  wire       el_enc    = (el_mode == cbac_pkg::MODE_PRIV) | (el_mode == cbac_pkg::MODE_FAM);
  wire       enc_now   = first ? el_enc : ((mode_q == cbac_pkg::MODE_PRIV) | (mode_q == cbac_pkg::MODE_FAM));
  // 8-bit add wraps, so 0x00 follows 0xff
  wire [7:0] succ      = prev_q + 8'h01;
  wire       el_ord    = ~first & enc_now & (elem.num != succ);
  // dummies at the tail of an encrypted list are never touched
  wire       el_used   = ~enc_now | ((8'(blk_n_q) + cbac_pkg::ENC_PARAM_BLK) < blk_m_q);
  wire       el_rng    = el_used & (elem.num >= NVM_LIM);
  wire       el_ro     = is_wr & rom_mask_q[elem.num[4:0]];
  wire       el_eo     = ~enc_now & enc_mask_q[elem.num[4:0]];
  wire       el_area   = el_used & ~el_rng & (el_ro | el_eo);

  always_ff @(posedge clk)
  begin
    if (!nrst || sel_cmd)
    begin
      blk_n_q    <= 5'h00;
      mode_q     <= cbac_pkg::MODE_PLAIN;
      prev_q     <= 8'h00;
      err_am_q   <= 1'b0;
      err_mode_q <= 1'b0;
      err_ord_q  <= 1'b0;
      err_rng_q  <= 1'b0;
      err_area_q <= 1'b0;
    end
    else if (blk_take)
    begin
      blk_n_q    <= blk_n_q + 5'h01;
      prev_q     <= elem.num;
      if (first)
        mode_q <= el_mode;
      err_am_q   <= err_am_q | el_am_bad;
      err_mode_q <= err_mode_q | ~el_known | el_hi_bad | el_differ;
      err_ord_q  <= err_ord_q | el_ord;
      err_rng_q  <= err_rng_q | el_rng;
      err_area_q <= err_area_q | el_area;
    end
  end

  // list memory has no reset, it is only read after a full intake
  always_ff @(posedge clk)
  begin
    if (blk_take)
      blk_num_q[blk_n_q[3:0]] <= elem.num;
  end

  // ********************************************
  // parameter check and status
  // ********************************************
  wire       enc_q   = (mode_q == cbac_pkg::MODE_PRIV) | (mode_q == cbac_pkg::MODE_FAM);
  wire [7:0] svc_max = is_rd ? cbac_pkg::SVC_MAX_RD : (is_wr ? cbac_pkg::SVC_MAX_WR : 8'h00);
  wire [7:0] blk_wr  = (svc_k_q <= cbac_pkg::SVC_WR_SPLIT) ? cbac_pkg::BLK_MAX_WR_LO : cbac_pkg::BLK_MAX_WR_HI;
  wire [7:0] blk_max = is_rd ? cbac_pkg::BLK_MAX_RD : (is_wr ? blk_wr : 8'h00);
  wire       svc_bad = (svc_k_q == 8'h00) | (svc_k_q > svc_max) | (8'(svc_n_q) != svc_k_q);
  // encrypted lists need at least one data block besides the two parameter blocks
  wire       enc_few = enc_q & (blk_m_q <= cbac_pkg::ENC_PARAM_BLK);
  wire       blk_bad = (blk_m_q == 8'h00) | (blk_m_q > blk_max) | (8'(blk_n_q) != blk_m_q) | enc_few;
  wire       spc_bad = err_am_q | err_mode_q | err_ord_q | err_rng_q;
  wire       eval    = sel_ctrl & avs_writedata[cbac_pkg::CTRL_EVAL_BIT] & collect;
  wire [7:0] unm_sf2 = unmnt_alt_q ? cbac_pkg::SF2_UNMNT_ALT : cbac_pkg::SF2_UNMNT;
  wire [7:0] chk_sf2 = unmnt_q    ? unm_sf2 :
                       svc_bad    ? cbac_pkg::SF2_SVC_CNT :
                       svc_diff_q ? cbac_pkg::SF2_SVC_DIFF :
                       blk_bad    ? cbac_pkg::SF2_BLK_CNT :
                       spc_bad    ? cbac_pkg::SF2_BLK_SPEC :
                       err_area_q ? cbac_pkg::SF2_AREA :
                       cbac_pkg::SF2_OK;
  wire       chk_ok  = (chk_sf2 == cbac_pkg::SF2_OK);

  logic [7:0] sf1_q;
  logic [7:0] sf2_q;

  always_ff @(posedge clk)
  begin
    if (!nrst || sel_cmd)
    begin
      sf1_q <= cbac_pkg::SF1_OK;
      sf2_q <= cbac_pkg::SF2_OK;
    end
    else if (eval)
    begin
      sf1_q <= chk_ok ? cbac_pkg::SF1_OK : cbac_pkg::SF1_ERR;
      sf2_q <= chk_sf2;
    end
  end

  // ********************************************
  // block access sequencer
  // ********************************************
  logic [3:0] idx_q;
  wire  [3:0] last_idx = blk_m_q[3:0] - 4'h1;
  wire        is_last  = (idx_q == last_idx);
  // payload slot j of an encrypted frame maps to list entry j-1
  wire  [3:0] ent_idx  = (enc_q & (idx_q != 4'h0)) ? idx_q - 4'h1 : idx_q;
  cbac_pkg::cbac_role_e role;

  assign role = ~enc_q          ? cbac_pkg::ROLE_DATA :
                (idx_q == 4'h0) ? cbac_pkg::ROLE_IV :
                is_last         ? cbac_pkg::ROLE_MAC :
                cbac_pkg::ROLE_DATA;

  always_ff @(posedge clk)
  begin
    if (!nrst || sel_cmd)
      state_q <= cbac_pkg::ST_COLLECT;
    else
    begin
      case (state_q)
        cbac_pkg::ST_COLLECT:
          if (eval)
            state_q <= chk_ok ? cbac_pkg::ST_ISSUE : cbac_pkg::ST_DONE;
        cbac_pkg::ST_ISSUE:
          if (is_last)
            state_q <= cbac_pkg::ST_DONE;
        cbac_pkg::ST_DONE:
          state_q <= cbac_pkg::ST_DONE;
        default:
          state_q <= cbac_pkg::ST_COLLECT;
      endcase
    end
  end

  wire issuing = (state_q == cbac_pkg::ST_ISSUE);

  always_ff @(posedge clk)
  begin
    if (!nrst || sel_cmd || !issuing)
      idx_q <= 4'h0;
    else
      idx_q <= idx_q + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      acc_valid <= 1'b0;
      acc       <= '0;
    end
    else
    begin
      acc_valid <= issuing & ~sel_cmd;
      acc.role  <= role;
      acc.nvm   <= (role == cbac_pkg::ROLE_DATA);
      acc.idx   <= idx_q;
      acc.num   <= blk_num_q[ent_idx];
    end
  end

  assign acc_bytes = 8'(BLK_BYTES);

  // ********************************************
  // response time
  // ********************************************
  wire [7:0]  rt_par = is_wr ? rtd_wr_q : rtd_rd_q;
  wire [19:0] rt_b1  = {17'h00000, rt_par[5:3]} + 20'h00001;
  wire [19:0] rt_a1  = {17'h00000, rt_par[2:0]} + 20'h00001;
  wire [19:0] rt_lin = 20'(rt_b1 * {12'h000, blk_m_q}) + rt_a1;
  wire [19:0] rt_t   = rt_lin << {rt_par[7:6], 1'b0};
  // reported in carrier periods so no rounding is needed
  wire [31:0] rt_fc  = 32'({12'h000, rt_t} * 32'(cbac_pkg::T_FC_PERIODS));

  // ********************************************
  // read data
  // ********************************************
  wire [31:0] rd_stat = {cbac_pkg::ANS_SLOT, 5'h00, enc_q, issuing,
                         (state_q == cbac_pkg::ST_DONE), sf2_q, sf1_q};
  wire [31:0] rd_dlo  = {cbac_pkg::RTD_ZERO, cbac_pkg::RTD_ZERO,
                         cbac_pkg::RTD_ONES, cbac_pkg::RTD_ONES};
  wire [31:0] rd_dhi  = {cbac_pkg::RTD_ONES, rtd_wr_q, rtd_rd_q, cbac_pkg::RTD_ZERO};
  wire [7:0]  n_used  = enc_q ? blk_m_q - cbac_pkg::ENC_PARAM_BLK : blk_m_q;
  wire [31:0] rd_acc  = {slot_req_q, 3'h0, blk_n_q, 3'h0, svc_n_q, n_used};
  wire [31:0] rd_cmd  = {slot_req_q, blk_m_q, svc_k_q, cmd_q};
  wire [31:0] rd_ctrl = {29'h00000000, unmnt_alt_q, unmnt_q, 1'b0};
  wire [31:0] rd_rtd  = {16'h0000, rtd_wr_q, rtd_rd_q};
  wire [31:0] rd_mux  = (addr == cbac_pkg::REG_CMD)  ? rd_cmd :
                        (addr == cbac_pkg::REG_CTRL) ? rd_ctrl :
                        (addr == cbac_pkg::REG_RTD)  ? rd_rtd :
                        (addr == cbac_pkg::REG_STAT) ? rd_stat :
                        (addr == cbac_pkg::REG_TIME) ? rt_fc :
                        (addr == cbac_pkg::REG_DLO)  ? rd_dlo :
                        (addr == cbac_pkg::REG_DHI)  ? rd_dhi :
                        (addr == cbac_pkg::REG_ROM)  ? rom_mask_q :
                        (addr == cbac_pkg::REG_ENC)  ? enc_mask_q :
                        (addr == cbac_pkg::REG_ACC)  ? rd_acc :
                        32'h00000000;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata_q <= 32'h00000000;
    else if (avs_read & ~resp_q)
      rdata_q <= rd_mux;
  end

endmodule // cbac_top

// ### include/cbac_pkg.sv
package cbac_pkg;

  // ********************************************
  // register map, byte addresses
  // ********************************************
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_SVC  = 8'h04;
  localparam logic [7:0] REG_BLK  = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_RTD  = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_TIME = 8'h18;
  localparam logic [7:0] REG_DLO  = 8'h1c;
  localparam logic [7:0] REG_DHI  = 8'h20;
  localparam logic [7:0] REG_ROM  = 8'h24;
  localparam logic [7:0] REG_ENC  = 8'h28;
  localparam logic [7:0] REG_ACC  = 8'h2c;

  // ********************************************
  // field positions and reset values
  // ********************************************
  localparam int CTRL_EVAL_BIT   = 0;
  localparam int CTRL_UNMNT_BIT  = 1;
  localparam int CTRL_ALT_BIT    = 2;
  localparam int STAT_DONE_BIT   = 16;
  localparam int STAT_BUSY_BIT   = 17;
  localparam int STAT_ENC_BIT    = 18;
  localparam logic [7:0]  RTD_RD_RST = 8'h00;
  localparam logic [7:0]  RTD_WR_RST = 8'h00;
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;

  // ********************************************
  // command codes and limits
  // ********************************************
  localparam logic [7:0] CMD_READ      = 8'h06;
  localparam logic [7:0] CMD_WRITE     = 8'h08;
  localparam logic [7:0] SVC_MAX_RD    = 8'h0f;
  localparam logic [7:0] SVC_MAX_WR    = 8'h0b;
  localparam logic [7:0] SVC_WR_SPLIT  = 8'h08;
  localparam logic [7:0] BLK_MAX_RD    = 8'h0f;
  localparam logic [7:0] BLK_MAX_WR_LO = 8'h0c;
  localparam logic [7:0] BLK_MAX_WR_HI = 8'h0b;
  localparam logic [7:0] ENC_PARAM_BLK = 8'h02;

  // ********************************************
  // status flag codes
  // ********************************************
  localparam logic [7:0] SF1_OK        = 8'h00;
  localparam logic [7:0] SF1_ERR       = 8'hff;
  localparam logic [7:0] SF2_OK        = 8'h00;
  localparam logic [7:0] SF2_UNMNT     = 8'h50;
  localparam logic [7:0] SF2_UNMNT_ALT = 8'h51;
  localparam logic [7:0] SF2_SVC_CNT   = 8'ha1;
  localparam logic [7:0] SF2_BLK_CNT   = 8'ha2;
  localparam logic [7:0] SF2_SVC_DIFF  = 8'ha3;
  localparam logic [7:0] SF2_BLK_SPEC  = 8'ha5;
  localparam logic [7:0] SF2_AREA      = 8'h60;

  // ********************************************
  // encryption modes, descriptor, timing
  // ********************************************
  localparam logic [2:0] MODE_PLAIN = 3'h0;
  localparam logic [2:0] MODE_PRIV  = 3'h2;
  localparam logic [2:0] MODE_FAM   = 3'h3;
  localparam logic [7:0] RTD_ONES   = 8'hff;
  localparam logic [7:0] RTD_ZERO   = 8'h00;
  localparam logic [7:0] ANS_SLOT   = 8'h00;
  localparam int T_FC_MULT    = 256;
  localparam int T_FC_DIV     = 16;
  localparam int T_FC_PERIODS = T_FC_MULT * T_FC_DIV;

  typedef enum logic [1:0] {ROLE_DATA, ROLE_IV, ROLE_MAC} cbac_role_e;
  typedef enum logic [1:0] {ST_COLLECT, ST_ISSUE, ST_DONE} cbac_state_e;

  typedef struct packed {
    logic       three;
    logic [7:0] d2;
    logic [7:0] num;
    logic [7:0] d0;
  } cbac_elem_s;

  typedef struct packed {
    cbac_role_e role;
    logic       nvm;
    logic [3:0] idx;
    logic [7:0] num;
  } cbac_acc_s;

endpackage

// ### test/cbac_asserts.sv
`timescale 1ns/100ps

module cbac_asserts #(
  parameter int NVM_BLOCKS = 32,
  parameter int LIST_MAX   = 15,
  parameter int BLK_BYTES  = 16
) (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic [7:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic                acc_valid,
  input wire cbac_pkg::cbac_acc_s acc,
  input wire logic [7:0]          acc_bytes
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  wire eval_acc = avs_write && !avs_waitrequest && avs_address[7:2] == cbac_pkg::REG_CTRL[7:2]
                  && avs_writedata[0] && avs_byteenable == 4'hf;

  // ********************************************
  // sequences
  // ********************************************
  sequence s_req_rise;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence s_rd_done(logic [7:0] a);
    avs_read && !avs_waitrequest && avs_address[7:2] == a[7:2];
  endsequence

  // ********************************************
  // properties
  // ********************************************
  property p_one_wait;
    s_req_rise |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  property p_slot;
    s_rd_done(cbac_pkg::REG_STAT) |-> avs_readdata[31:24] == 8'h00;
  endproperty
  property p_dlo;
    s_rd_done(cbac_pkg::REG_DLO) |-> avs_readdata == 32'h0000ffff;
  endproperty
  property p_dhi;
    s_rd_done(cbac_pkg::REG_DHI) |-> avs_readdata[31:24] == 8'hff && avs_readdata[7:0] == 8'h00;
  endproperty
  property p_err_sf1;
    s_rd_done(cbac_pkg::REG_STAT) ##0 (avs_readdata[16] && avs_readdata[15:8] != 8'h00)
      |-> avs_readdata[7:0] == 8'hff;
  endproperty
  property p_bytes;
    acc_bytes == 8'(BLK_BYTES);
  endproperty
  property p_iv_first;
    acc_valid && acc.role == cbac_pkg::ROLE_IV |-> acc.idx == 4'h0 && !acc.nvm;
  endproperty
  property p_mac_end;
    acc_valid && acc.role == cbac_pkg::ROLE_MAC |-> !acc.nvm ##1 !acc_valid;
  endproperty
  property p_data_nvm;
    acc_valid && acc.role == cbac_pkg::ROLE_DATA |-> acc.nvm && acc.num < NVM_BLOCKS;
  endproperty
  property p_idx_step;
    acc_valid && acc.idx != 4'h0 |-> $past(acc_valid) && acc.idx == $past(acc.idx) + 4'h1;
  endproperty
  property p_start;
    acc_valid && acc.idx == 4'h0 |-> $past(eval_acc, 2);
  endproperty

  a_one_wait:  assert property (p_one_wait)  else $error("waitrequest not exactly one cycle");
  a_slot:      assert property (p_slot)      else $error("answer slot not zero");
  a_dlo:       assert property (p_dlo)       else $error("descriptor low word wrong");
  a_dhi:       assert property (p_dhi)       else $error("descriptor high fixed bytes wrong");
  a_err_sf1:   assert property (p_err_sf1)   else $error("error without flag one set");
  a_bytes:     assert property (p_bytes)     else $error("block length wrong");
  a_iv_first:  assert property (p_iv_first)  else $error("vector block misplaced");
  a_mac_end:   assert property (p_mac_end)   else $error("auth block not last");
  a_data_nvm:  assert property (p_data_nvm)  else $error("data access out of memory");
  a_idx_step:  assert property (p_idx_step)  else $error("access index not consecutive");
  a_start:     assert property (p_start)     else $error("access without evaluate");
endmodule // cbac_asserts

// ### test/cbac_nvm_model.sv
`timescale 1ns/100ps

// memory-side sink: logs every block slot so the bench can replay it
module cbac_nvm_model (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                acc_valid,
  input wire cbac_pkg::cbac_acc_s acc,
  input wire logic [7:0]          acc_bytes
);
  cbac_pkg::cbac_acc_s log_q [256];
  int                  n_acc   = 0;
  int                  n_bytes = 0;

  always @(posedge clk)
  begin
    if (nrst === 1'b1 && acc_valid === 1'b1)
    begin
      log_q[n_acc[7:0]] <= acc;
      n_acc             <= n_acc + 1;
      if (acc.nvm === 1'b1)
        n_bytes <= n_bytes + int'(acc_bytes);
    end
  end
endmodule // cbac_nvm_model

// ### test/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] k;
    logic [7:0] m;
    logic       diff;
    logic       mix;
    logic       three;
    logic [1:0] rsv;
    logic [2:0] ctrl;
    logic [7:0] d0;
    logic [7:0] d2;
    logic [7:0] n0;
    logic [7:0] step;
    logic [7:0] sf2;
  } cbac_case_s;

  logic                clk            = 1'b0;
  logic                nrst           = 1'b0;
  logic [7:0]          avs_address    = 8'h00;
  logic                avs_read       = 1'b0;
  logic                avs_write      = 1'b0;
  logic [31:0]         avs_writedata  = 32'h0;
  logic [3:0]          avs_byteenable = 4'hf;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                acc_valid;
  cbac_pkg::cbac_acc_s acc;
  logic [7:0]          acc_bytes;
  int                  n_errors = 0;
  int                  n_checks = 0;
  cbac_case_s          tc [24];

  cbac_top #(.NVM_BLOCKS(32), .LIST_MAX(15), .BLK_BYTES(16)) DUT (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid), .acc(acc), .acc_bytes(acc_bytes));
  cbac_nvm_model u_nvm (.clk(clk), .nrst(nrst), .acc_valid(acc_valid), .acc(acc), .acc_bytes(acc_bytes));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // ********************************************
  // reporting
  // ********************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // ********************************************
  // bus master: hold until waitrequest low at a rising edge
  // ********************************************
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic w;
    int   n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    w = 1'b1;
    n = 0;
    while (w !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (w !== 1'b0)
    begin
      n_errors++;
      conclude;
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 32'h0, q);
  endtask

  function automatic logic [7:0] bnum(input cbac_case_s c, input int i);
    return c.n0 + c.step * i[7:0];
  endfunction

  function automatic logic [31:0] exp_time(input logic [7:0] p, input logic [7:0] m);
    return (32'(cbac_pkg::T_FC_PERIODS) * ((32'(p[5:3]) + 32'h1) * 32'(m) + 32'(p[2:0]) + 32'h1)) << (2 * p[7:6]);
  endfunction

  // ********************************************
  // one command: load lists, evaluate, judge status and accesses
  // ********************************************
  task automatic run_case(input cbac_case_s c);
    logic [31:0]          q;
    logic                 enc;
    logic                 dat;
    int                   base;
    int                   n;
    int                   nb;
    cbac_pkg::cbac_acc_s  e;
    cbac_pkg::cbac_role_e r;
    base = u_nvm.n_acc;
    nb   = u_nvm.n_bytes;
    enc  = c.three && (c.d2[2:0] != 3'h0);
    bus_wr(cbac_pkg::REG_CMD, {8'h05, c.m, c.k, c.cmd});
    for (int i = 0; i < int'(c.k); i++)
      bus_wr(cbac_pkg::REG_SVC, {16'h0000, 15'h0480, c.diff && (i == int'(c.k) - 1)});
    for (int i = 0; i < int'(c.m); i++)
      bus_wr(cbac_pkg::REG_BLK, {7'h00, c.three && !(c.mix && i == int'(c.m) - 1), c.d2, bnum(c, i), c.d0});
    // mode bits only act on a later evaluate, so set them first
    bus_wr(cbac_pkg::REG_CTRL, {29'h0, c.ctrl & 3'b110});
    bus_wr(cbac_pkg::REG_CTRL, {29'h0, c.ctrl});
    n = 0;
    q = 32'h0;
    while (q[cbac_pkg::STAT_DONE_BIT] !== 1'b1 && n < 20)
    begin
      bus_rd(cbac_pkg::REG_STAT, q);
      n++;
    end
    if (q[cbac_pkg::STAT_DONE_BIT] !== 1'b1)
    begin
      n_errors++;
      conclude;
    end
    check({6'h0, q[31:24], q[17:0]}, {6'h0, 8'h00, 2'b01, c.sf2, (c.sf2 == 8'h00) ? 8'h00 : 8'hff});
    check(32'(u_nvm.n_acc - base), (c.sf2 == 8'h00) ? 32'(c.m) : 32'h0);
    check(32'(u_nvm.n_bytes - nb), (c.sf2 == 8'h00) ? 32'(enc ? c.m - 8'h02 : c.m) * 32'h10 : 32'h0);
    if (c.sf2 == 8'h00)
    begin
      bus_rd(cbac_pkg::REG_TIME, q);
      check(q, exp_time((c.cmd == cbac_pkg::CMD_WRITE) ? 8'h8a : 8'h51, c.m));
      bus_rd(cbac_pkg::REG_STAT, q);
      check({31'h0, q[cbac_pkg::STAT_ENC_BIT]}, {31'h0, enc});
      bus_rd(cbac_pkg::REG_ACC, q);
      check({24'h0, q[7:0]}, {24'h0, enc ? c.m - 8'h02 : c.m});
      check({11'h0, q[31:24], q[20:16], 3'h0, q[12:8]}, {11'h0, 8'h05, 5'(c.m), 3'h0, 5'(c.k)});
      for (int i = 0; i < int'(c.m); i++)
      begin
        e   = u_nvm.log_q[8'(base + i)];
        r   = (enc && i == 0) ? cbac_pkg::ROLE_IV : (enc && i == int'(c.m) - 1) ? cbac_pkg::ROLE_MAC : cbac_pkg::ROLE_DATA;
        dat = (r == cbac_pkg::ROLE_DATA);
        check({17'h0, e.role, e.nvm, e.idx, dat ? e.num : 8'h00},
              {17'h0, r, dat, 4'(i), dat ? bnum(c, enc ? i - 1 : i) : 8'h00});
      end
    end
  endtask

  // ********************************************
  // main sequence
  // ********************************************
  initial
  begin
    logic [31:0] q;
    // cmd k m | diff mix three - ctrl | d0 d2 n0 step | sf2
    tc[0]  = 72'h060303_01_00000cfd_00;
    tc[1]  = 72'h060f0f_21_00000501_00;
    tc[2]  = 72'h080204_21_00020501_00;
    tc[3]  = 72'h060103_21_00030401_00;
    tc[4]  = 72'h08080c_01_00000a01_00;
    tc[5]  = 72'h080b0b_01_00000a01_00;
    tc[6]  = 72'h060001_01_00000101_a1;
    tc[7]  = 72'h080c01_01_00000101_a1;
    tc[8]  = 72'h070101_01_00000101_a1;
    tc[9]  = 72'h060201_81_00000101_a3;
    tc[10] = 72'h060110_01_00000101_a2;
    tc[11] = 72'h08090c_01_00000a01_a2;
    tc[12] = 72'h060102_21_00020501_a2;
    tc[13] = 72'h060101_01_10000101_a5;
    tc[14] = 72'h060101_21_00010101_a5;
    tc[15] = 72'h060101_21_00080101_a5;
    tc[16] = 72'h060103_61_00020501_a5;
    tc[17] = 72'h060104_21_00020502_a5;
    tc[18] = 72'h060101_01_00002001_a5;
    tc[19] = 72'h080101_01_00000301_60;
    tc[20] = 72'h060101_01_00000401_60;
    tc[21] = 72'h060104_21_0002fe01_a5;
    tc[22] = 72'h060101_03_00000101_50;
    tc[23] = 72'h060101_07_00000101_51;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    bus_rd(cbac_pkg::REG_DLO, q);
    check(q, 32'h0000ffff);
    bus_rd(cbac_pkg::REG_DHI, q);
    check(q, 32'hff000000);
    bus_rd(cbac_pkg::REG_RTD, q);
    check(q, {16'h0, cbac_pkg::RTD_WR_RST, cbac_pkg::RTD_RD_RST});
    check({24'h0, acc_bytes}, 32'h10);
    bus_rd(8'h3c, q);
    check(q, 32'h0);
    bus_wr(cbac_pkg::REG_RTD, 32'h00008a51);
    bus_rd(cbac_pkg::REG_DHI, q);
    check(q, 32'hff8a5100);
    bus_wr(cbac_pkg::REG_ROM, 32'h00000008);
    bus_wr(cbac_pkg::REG_ENC, 32'h00000010);
    $display("test registers done");
    for (int i = 0; i < 24; i++)
    begin
      run_case(tc[i]);
      $display("test case %0d done", i);
    end
    conclude;
  end
endmodule // tb_top

bind cbac_top cbac_asserts #(.NVM_BLOCKS(NVM_BLOCKS), .LIST_MAX(LIST_MAX), .BLK_BYTES(BLK_BYTES)) u_asserts (
  .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid), .acc(acc), .acc_bytes(acc_bytes));
